// [src/scd_pkg.sv]
/*
 * Package for the standalone strap decoder and duty-cycle sequencer.
 * Assumes a 125 MHz core clock; all timing counts derive from it.
 */
package scd_pkg;
    localparam int unsigned CLK_MHZ          = 125;
    // Times in microseconds as specified
    localparam int unsigned XTAL_SETTLE_US   = 2250;
    localparam int unsigned RSSI_WINDOW_US   = 6000;
    localparam int unsigned EXTEND_US        = 30500;
    localparam int unsigned WAKE_PERIOD_US   = 300000;
    localparam int unsigned MONO_US          = 100000;
    localparam int unsigned XTAL_SETTLE_CYC  = XTAL_SETTLE_US * CLK_MHZ;
    localparam int unsigned RSSI_WINDOW_CYC  = RSSI_WINDOW_US * CLK_MHZ;
    localparam int unsigned EXTEND_CYC       = EXTEND_US * CLK_MHZ;
    localparam int unsigned WAKE_PERIOD_CYC  = WAKE_PERIOD_US * CLK_MHZ;
    localparam int unsigned MONO_CYC         = MONO_US * CLK_MHZ;
    localparam int unsigned CNT_W            = 26;

    // Frame bytes
    localparam logic [7:0] PREAMBLE_BYTE     = 8'haa;
    localparam logic [7:0] SYNC_BYTE         = 8'h2d;
    localparam logic [7:0] ADDR_0            = 8'hd4;
    localparam logic [7:0] ADDR_1            = 8'hd2;
    localparam logic [7:0] ADDR_2            = 8'hb4;
    localparam logic [7:0] ADDR_3            = 8'hb2;

    // Output function codes
    localparam logic [1:0] FN_KEEP           = 2'h0;
    localparam logic [1:0] FN_LOW            = 2'h1;
    localparam logic [1:0] FN_HIGH           = 2'h2;
    localparam logic [1:0] FN_MONO           = 2'h3;

    // RSSI thresholds in -dBm
    localparam logic [6:0] RSSI_LOW_THR      = 7'h67;
    localparam logic [6:0] RSSI_HIGH_THR     = 7'h61;

    // Crystal load: 8.5 pF + code * 0.5 pF, code 0..15 -> 16 pF at code 15
    localparam logic [3:0] XLOAD_MAX_CODE    = 4'hf;
    localparam logic [3:0] XLOAD_POR         = 4'h7;

    typedef enum logic [2:0] {
        SCD_SLEEP, SCD_XTAL, SCD_WINDOW, SCD_EXTEND, SCD_ACTIVE
    } scd_seq_e;

    typedef enum logic [2:0] {
        SCD_HUNT, SCD_ADDR, SCD_FN1, SCD_FNC, SCD_FN2
    } scd_frm_e;

    typedef struct packed {
        logic [1:0] band;
        logic [3:0] channel;
        logic [7:0] addr;
        logic [6:0] rssi_thr;
    } scd_cfg_s;

    typedef struct packed {
        logic       xtal_en;
        logic       synth_en;
        logic       rssi_mon;
    } scd_pwr_s;
endpackage : scd_pkg

// [src/scd_standalone.sv]
/*
 * Standalone strap decoder, duty-cycle wake sequencer and frame-driven
 * output controller. Assumes the straps are resolved to 0/1 levels by
 * pad logic, the demodulator delivers bytes with a strobe on core_clk,
 * and the serial control port lives elsewhere and drives host_* ports.
 */
`timescale 1ns/10ps
module scd_standalone
    import scd_pkg::*;
#(
    parameter int unsigned WAKE_PERIOD = WAKE_PERIOD_CYC,
    parameter int unsigned XTAL_SETTLE = XTAL_SETTLE_CYC,
    parameter int unsigned RSSI_WINDOW = RSSI_WINDOW_CYC,
    parameter int unsigned EXTEND      = EXTEND_CYC,
    parameter int unsigned MONO        = MONO_CYC
) (
    input  wire logic              core_clk,
    input  wire logic              resetn,
    input  wire logic              mode_pin_rail,
    input  wire logic              low_power_wake_mode,
    input  wire logic [1:0]        band_pins,
    input  wire logic              chan_strap_3,
    input  wire logic              chan_strap_2,
    input  wire logic              chan_strap_1,
    input  wire logic              chan_strap_0,
    input  wire logic              rssi_above,
    input  wire logic              rx_byte_valid,
    input  wire logic [7:0]        rx_byte,
    input  wire logic [6:0]        afc_offset,
    input  wire logic              host_wr,
    input  wire logic              host_xload_wr,
    input  wire logic [3:0]        host_xload,
    input  wire logic              host_afc_en,
    output scd_pkg::scd_cfg_s      cfg,
    output scd_pkg::scd_pwr_s      pwr,
    output logic                   standalone,
    output logic                   host_override,
    output logic [3:0]             xtal_load,
    output logic [6:0]             offset_status,
    output logic                   remote_output_0,
    output logic                   remote_output_1,
    output logic                   remote_output_2,
    output logic                   remote_output_3
);
    import scd_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [11:0] sync_a;
    logic [11:0] sync_b;
    always_ff @(posedge core_clk) begin
        sync_a <= {mode_pin_rail, low_power_wake_mode, band_pins, chan_strap_3,
                   chan_strap_2, chan_strap_1, chan_strap_0, rssi_above, 3'h0};
        sync_b <= sync_a;
    end
    logic s_rail;
    logic s_low_power_wake_mode;
    logic [1:0] s_band;
    logic [3:0] s_chan;
    logic s_rssi;
    assign s_rail = sync_b[11];
    assign s_low_power_wake_mode = sync_b[10];
    assign s_band = sync_b[9:8];
    assign s_chan = sync_b[7:4];
    assign s_rssi = sync_b[3];

    function automatic logic [7:0] addr_of(input logic [1:0] sel);
        case (sel)
            2'h0:    addr_of = ADDR_0;
            2'h1:    addr_of = ADDR_1;
            2'h2:    addr_of = ADDR_2;
            default: addr_of = ADDR_3;
        endcase
    endfunction : addr_of

    ////////////////////////////////////////////////////////////////////////
    // Strap capture and configuration
    logic       sampled;
    logic       next_sampled;
    logic       next_standalone;
    scd_cfg_s   next_cfg;
    logic       next_host_override;
    logic [3:0] next_xtal_load;
    logic [6:0] next_offset_status;

    always_comb begin
        next_sampled       = sampled;
        next_standalone    = standalone;
        next_cfg           = cfg;
        next_host_override = host_override | host_wr;
        next_xtal_load     = xtal_load;
        next_offset_status = offset_status;
        if (!sampled) begin
            // Caught after reset release, once synchronisers have settled
            next_sampled    = 1'b1;
            next_standalone = s_rail;
        end
        if (standalone) begin
            next_cfg.band     = s_band;
            // Floating reads as 1; a supply tie on strap 0 counts as floating
            next_cfg.channel  = s_chan;
            next_cfg.addr     = addr_of(s_chan[1:0]);
            next_cfg.rssi_thr = s_chan[0] ? RSSI_HIGH_THR : RSSI_LOW_THR;
        end
        if (host_xload_wr && host_xload <= XLOAD_MAX_CODE) begin
            next_xtal_load = host_xload;
        end
        // Offset is meaningful only with correction held off by the host
        if (!host_afc_en) begin
            next_offset_status = afc_offset;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            sampled       <= 1'b0;
            standalone    <= 1'b0;
            cfg           <= '0;
            host_override <= 1'b0;
            xtal_load     <= XLOAD_POR;
            offset_status <= 7'h00;
        end else begin
            sampled       <= next_sampled;
            standalone    <= next_standalone;
            cfg           <= next_cfg;
            host_override <= next_host_override;
            xtal_load     <= next_xtal_load;
            offset_status <= next_offset_status;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Frame decoder
    scd_frm_e   frm;
    scd_frm_e   next_frm;
    logic [7:0] fn1;
    logic [7:0] next_fn1;
    logic       frm_ok;
    logic       next_frm_ok;
    logic       sync_hit;
    logic       next_sync_hit;

    always_comb begin
        next_frm      = frm;
        next_fn1      = fn1;
        next_frm_ok   = 1'b0;
        next_sync_hit = 1'b0;
        if (rx_byte_valid && standalone) begin
            case (frm)
                SCD_HUNT: begin
                    if (rx_byte == SYNC_BYTE) begin
                        next_frm      = SCD_ADDR;
                        next_sync_hit = 1'b1;
                    end
                end
                SCD_ADDR: next_frm = (rx_byte == cfg.addr) ? SCD_FN1 : SCD_HUNT;
                SCD_FN1: begin
                    next_fn1 = rx_byte;
                    next_frm = SCD_FNC;
                end
                SCD_FNC:  next_frm = (rx_byte == ~fn1) ? SCD_FN2 : SCD_HUNT;
                SCD_FN2: begin
                    next_frm_ok = (rx_byte == fn1);
                    next_frm    = SCD_HUNT;
                end
                default:  next_frm = SCD_HUNT;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            frm      <= SCD_HUNT;
            fn1      <= 8'h00;
            frm_ok   <= 1'b0;
            sync_hit <= 1'b0;
        end else begin
            frm      <= next_frm;
            fn1      <= next_fn1;
            frm_ok   <= next_frm_ok;
            sync_hit <= next_sync_hit;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output functions; fn1[7:6] belongs to output 3 (sent first)
    logic [3:0]       outs;
    logic [3:0]       next_outs;
    logic [3:0][26:0] mono;
    logic [3:0][26:0] next_mono;

    always_comb begin
        next_outs = outs;
        next_mono = mono;
        for (int i = 0; i < 4; i++) begin
            if (mono[i] != 27'h0) begin
                next_mono[i] = mono[i] - 27'h1;
                if (mono[i] == 27'h1) begin
                    next_outs[i] = 1'b0;
                end
            end
            if (frm_ok) begin
                case (fn1[2*i+1 -: 2])
                    FN_LOW: begin
                        next_outs[i] = 1'b0;
                        next_mono[i] = 27'h0;
                    end
                    FN_HIGH: begin
                        next_outs[i] = 1'b1;
                        next_mono[i] = 27'h0;
                    end
                    FN_MONO: begin
                        next_outs[i] = 1'b1;
                        next_mono[i] = 27'(MONO);
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            outs <= 4'h0;
            mono <= '0;
        end else begin
            outs <= next_outs;
            mono <= next_mono;
        end
    end
    assign remote_output_0 = outs[0];
    assign remote_output_1 = outs[1];
    assign remote_output_2 = outs[2];
    assign remote_output_3 = outs[3];

    ////////////////////////////////////////////////////////////////////////
    // Duty-cycle sequencer
    scd_seq_e         seq;
    scd_seq_e         next_seq;
    logic [CNT_W-1:0] tmr;
    logic [CNT_W-1:0] next_tmr;
    logic [CNT_W-1:0] wake;
    logic [CNT_W-1:0] next_wake;
    scd_pwr_s         next_pwr;
    logic             busy;
    logic             hit;
    logic             next_hit;

    // A frame past the sync byte must finish before the synth drops, except on leaving SCD_ACTIVE for SCD_SLEEP
    assign busy = (frm != SCD_HUNT);

    always_comb begin
        next_seq  = seq;
        next_tmr  = (tmr != '0) ? tmr - 1'b1 : tmr;
        next_wake = (wake != '0) ? wake - 1'b1 : CNT_W'(WAKE_PERIOD - 1);
        next_hit  = hit;
        case (seq)
            SCD_ACTIVE: begin
                if (sampled && s_low_power_wake_mode) begin
                    next_seq = SCD_SLEEP;
                end
            end
            SCD_SLEEP: begin
                if (!s_low_power_wake_mode) begin
                    next_seq = SCD_ACTIVE;
                end else if (wake == '0) begin
                    next_seq = SCD_XTAL;
                    next_tmr = CNT_W'(XTAL_SETTLE - 1);
                end
            end
            SCD_XTAL: begin
                if (tmr == '0) begin
                    next_seq = SCD_WINDOW;
                    next_tmr = CNT_W'(RSSI_WINDOW - 1);
                    next_hit = 1'b0;
                end
            end
            SCD_WINDOW: begin
                if (s_rssi) begin
                    next_hit = 1'b1;
                end
                if (tmr == '0 && (hit || s_rssi)) begin
                    next_seq = SCD_EXTEND;
                    next_tmr = CNT_W'(EXTEND - 1);
                end else if (tmr == '0 && !busy) begin
                    next_seq = SCD_SLEEP;
                end
            end
            SCD_EXTEND: begin
                if (tmr == '0 && !busy) begin
                    next_seq = SCD_SLEEP;
                end
            end
            default: next_seq = SCD_ACTIVE;
        endcase
        if (sync_hit && (seq == SCD_WINDOW || seq == SCD_EXTEND)) begin
            next_seq = SCD_EXTEND;
            next_tmr = CNT_W'(EXTEND - 1);
        end
        // Mode pin low wins from any phase, not only from sleep
        if (!s_low_power_wake_mode) begin
            next_seq = SCD_ACTIVE;
        end
        next_pwr.xtal_en  = (next_seq != SCD_SLEEP);
        next_pwr.synth_en = (next_seq == SCD_WINDOW) || (next_seq == SCD_EXTEND)
                            || (next_seq == SCD_ACTIVE);
        next_pwr.rssi_mon = next_pwr.synth_en;
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            seq  <= SCD_ACTIVE;
            tmr  <= '0;
            wake <= '0;
            hit  <= 1'b0;
            pwr  <= '0;
        end else begin
            seq  <= next_seq;
            tmr  <= next_tmr;
            wake <= next_wake;
            hit  <= next_hit;
            pwr  <= next_pwr;
        end
    end
endmodule : scd_standalone

// [verification/scd_checker_asserts.sv]
/*
 * Port checker for scd_standalone: strap decoding, power sequencing,
 * output refusal and host-side holds.
 * Assumes the single core_clk domain and its synchronous resetn.
 */
`timescale 1ns/10ps
module scd_checker
    import scd_pkg::*;
(
    input wire logic           core_clk,
    input wire logic           resetn,
    input wire logic           low_power_wake_mode,
    input wire logic [1:0]     band_pins,
    input wire logic           chan_strap_3,
    input wire logic           chan_strap_2,
    input wire logic           chan_strap_1,
    input wire logic           chan_strap_0,
    input wire logic           host_xload_wr,
    input wire logic [3:0]     host_xload,
    input wire logic           host_afc_en,
    input wire scd_pkg::scd_cfg_s cfg,
    input wire scd_pkg::scd_pwr_s pwr,
    input wire logic           standalone,
    input wire logic [3:0]     xtal_load,
    input wire logic [6:0]     offset_status,
    input wire logic           remote_output_0,
    input wire logic           remote_output_1,
    input wire logic           remote_output_2,
    input wire logic           remote_output_3
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    // Straps pass a synchroniser, so only settled pins are judged
    sequence straps_settled;
        standalone && $past(standalone, 4) ##0
        $stable({chan_strap_3, chan_strap_2, chan_strap_1, chan_strap_0, band_pins})[*5];
    endsequence

    a_addr_map: assert property (straps_settled |-> cfg.addr == (chan_strap_1 ?
        (chan_strap_0 ? ADDR_3 : ADDR_2) : (chan_strap_0 ? ADDR_1 : ADDR_0)))
        else $error("address byte does not follow straps");
    a_chan_band: assert property (straps_settled |-> cfg.band == band_pins &&
        cfg.channel == {chan_strap_3, chan_strap_2, chan_strap_1, chan_strap_0})
        else $error("band or channel does not follow straps");
    a_rssi_thr: assert property (straps_settled |->
        cfg.rssi_thr == (chan_strap_0 ? RSSI_HIGH_THR : RSSI_LOW_THR))
        else $error("signal threshold wrong for strap 0");
    a_always_on: assert property (!low_power_wake_mode [*5] |-> pwr == 3'b111)
        else $error("receiver not fully on with wake mode low");
    a_xtal_first: assert property ($rose(pwr.synth_en) && $past(resetn) &&
        low_power_wake_mode && $past(low_power_wake_mode, 4) |-> $past(pwr.xtal_en))
        else $error("synthesizer enabled before oscillator");
    a_xload_wr: assert property (host_xload_wr |=> xtal_load == $past(host_xload))
        else $error("crystal load code not taken");
    a_offset_hold: assert property (host_afc_en [*4] |=> $stable(offset_status))
        else $error("offset status moved while correction enabled");
    a_refuse_host: assert property (!standalone |=> $stable({remote_output_3,
        remote_output_2, remote_output_1, remote_output_0}))
        else $error("outputs moved outside standalone mode");
    a_mode_hold: assert property ($past(resetn, 2) |-> $stable(standalone))
        else $error("standalone flag changed without reset");
endmodule : scd_checker

bind scd_standalone scd_checker u_scd_checker (
    .core_clk(core_clk), .resetn(resetn), .low_power_wake_mode(low_power_wake_mode),
    .band_pins(band_pins), .chan_strap_3(chan_strap_3), .chan_strap_2(chan_strap_2),
    .chan_strap_1(chan_strap_1), .chan_strap_0(chan_strap_0),
    .host_xload_wr(host_xload_wr), .host_xload(host_xload), .host_afc_en(host_afc_en),
    .cfg(cfg), .pwr(pwr), .standalone(standalone), .xtal_load(xtal_load),
    .offset_status(offset_status), .remote_output_0(remote_output_0),
    .remote_output_1(remote_output_1), .remote_output_2(remote_output_2),
    .remote_output_3(remote_output_3)
);

// [verification/scd_remote_tx.sv]
/*
 * Remote transmitter model: sends addressed command frames as bytes.
 * Assumes the demodulator interface: one-cycle strobe per byte.
 */
`timescale 1ns/10ps
module scd_remote_tx
    import scd_pkg::*;
(
    input  wire logic       core_clk,
    output logic            rx_byte_valid,
    output logic [7:0]      rx_byte
);
    initial begin
        rx_byte_valid = 1'b0;
        rx_byte = 8'h00;
    end

    task automatic put_byte(input logic [7:0] b);
        @(posedge core_clk);
        #1;
        rx_byte_valid = 1'b1;
        rx_byte = b;
        @(posedge core_clk);
        #1;
        rx_byte_valid = 1'b0;
        // Byte no longer valid, so do not leave it on the lines
        rx_byte = ~b;
    endtask : put_byte

    // Output 3 code in the top bits, sent first
    task automatic send_frame(input logic [7:0] addr, input logic [7:0] fn,
                              input logic [7:0] fn_inv);
        put_byte(PREAMBLE_BYTE);
        put_byte(PREAMBLE_BYTE);
        put_byte(SYNC_BYTE);
        put_byte(addr);
        put_byte(fn);
        put_byte(fn_inv);
        put_byte(fn);
    endtask : send_frame
endmodule : scd_remote_tx

// [verification/scd_standalone_bench.sv]
/*
 * Self-checking bench for scd_standalone with a remote transmitter model.
 * Assumes shortened timing parameters and the checker bound to the top.
 */
`timescale 1ns/10ps
module scd_standalone_bench;
    import scd_pkg::*;
    typedef struct packed {
        logic [3:0] straps;
        logic [1:0] band;
        logic [7:0] addr;
        logic [6:0] thr;
        logic [7:0] fn;
        logic [3:0] outs;
    } scd_row_s;
    logic core_clk, resetn, mode_pin_rail, low_power_wake_mode, rssi_above;
    logic chan_strap_3, chan_strap_2, chan_strap_1, chan_strap_0;
    logic host_wr, host_xload_wr, host_afc_en, rx_byte_valid, standalone, host_override;
    logic remote_output_0, remote_output_1, remote_output_2, remote_output_3;
    logic [1:0] band_pins;
    logic [7:0] rx_byte;
    logic [6:0] afc_offset, offset_status;
    logic [3:0] host_xload, xtal_load;
    scd_cfg_s   cfg;
    scd_pwr_s   pwr;
    int         fails, checks_done;
    wire  [3:0] outs = {remote_output_3, remote_output_2, remote_output_1, remote_output_0};
    scd_row_s   rows [4] = '{
        '{4'h0, 2'h0, 8'hd4, 7'h67, 8'h66, 4'h5},
        '{4'h9, 2'h1, 8'hd2, 7'h61, 8'h00, 4'h5},
        '{4'h6, 2'h2, 8'hb4, 7'h67, 8'h99, 4'ha},
        '{4'hf, 2'h3, 8'hb2, 7'h61, 8'h1e, 4'hb}};

    scd_standalone #(.WAKE_PERIOD(20), .XTAL_SETTLE(4), .RSSI_WINDOW(8), .EXTEND(16),
        .MONO(30)) u_scd_standalone (.core_clk(core_clk), .resetn(resetn),
        .mode_pin_rail(mode_pin_rail), .low_power_wake_mode(low_power_wake_mode),
        .band_pins(band_pins), .chan_strap_3(chan_strap_3), .chan_strap_2(chan_strap_2),
        .chan_strap_1(chan_strap_1), .chan_strap_0(chan_strap_0), .rssi_above(rssi_above),
        .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte), .afc_offset(afc_offset),
        .host_wr(host_wr), .host_xload_wr(host_xload_wr), .host_xload(host_xload),
        .host_afc_en(host_afc_en), .cfg(cfg), .pwr(pwr), .standalone(standalone),
        .host_override(host_override), .xtal_load(xtal_load),
        .offset_status(offset_status), .remote_output_0(remote_output_0),
        .remote_output_1(remote_output_1), .remote_output_2(remote_output_2),
        .remote_output_3(remote_output_3));
    scd_remote_tx u_remote_tx (.core_clk(core_clk), .rx_byte_valid(rx_byte_valid),
        .rx_byte(rx_byte));

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : cyc

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic close_out;
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : close_out

    // Pins held through reset, past the synchroniser depth
    task automatic do_reset(input logic rail);
        resetn = 1'b0;
        mode_pin_rail = rail;
        cyc(4);
        resetn = 1'b1;
        cyc(6);
    endtask : do_reset

    task automatic wait_pwr(input logic [2:0] mask, input logic [2:0] want, input int lim);
        int n;
        n = 0;
        while (((pwr & mask) !== want) && n < lim) begin
            cyc(1);
            n++;
        end
    endtask : wait_pwr

    initial begin
        repeat (6000) @(posedge core_clk);
        fails++;
        close_out();
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {chan_strap_3, chan_strap_2, chan_strap_1, chan_strap_0} = 4'h0;
        {low_power_wake_mode, rssi_above, host_wr, host_xload_wr, host_afc_en} = 5'h0;
        band_pins = 2'h0;
        host_xload = 4'h0;
        afc_offset = 7'h23;
        fails = 0;
        checks_done = 0;
        #1;
        do_reset(1'b1);
        check("standalone", standalone, 1'b1);
        check("xtal_load", xtal_load, 4'h7);
        check("pwr", pwr, 3'b111);
        foreach (rows[i]) begin
            {chan_strap_3, chan_strap_2, chan_strap_1, chan_strap_0} = rows[i].straps;
            band_pins = rows[i].band;
            cyc(6);
            check("addr", cfg.addr, rows[i].addr);
            check("channel", {cfg.band, cfg.channel}, {rows[i].band, rows[i].straps});
            check("rssi_thr", cfg.rssi_thr, rows[i].thr);
            u_remote_tx.send_frame(rows[i].addr, rows[i].fn, ~rows[i].fn);
            cyc(2);
            check("outs", outs, rows[i].outs);
        end
        cyc(35);
        check("mono_end", outs, 4'h9);
        u_remote_tx.send_frame(8'hb2, 8'h55, 8'h55);
        cyc(2);
        check("bad_inv", outs, 4'h9);
        u_remote_tx.send_frame(8'hd4, 8'h55, 8'haa);
        cyc(2);
        check("bad_addr", outs, 4'h9);
        u_remote_tx.send_frame(8'hb2, 8'h0c, 8'hf3);
        u_remote_tx.send_frame(8'hb2, 8'h0c, 8'hf3);
        cyc(24);
        check("retrigger", outs, 4'hb);
        cyc(10);
        check("mono_end2", outs, 4'h9);
        host_xload = 4'hf;
        host_xload_wr = 1'b1;
        host_wr = 1'b1;
        cyc(1);
        {host_xload_wr, host_wr} = 2'h0;
        cyc(1);
        check("xtal_load", xtal_load, 4'hf);
        check("override", host_override, 1'b1);
        u_remote_tx.send_frame(8'hb2, 8'h55, 8'haa);
        cyc(2);
        check("mixed_outs", outs, 4'h0);
        check("offset", offset_status, 7'h23);
        host_afc_en = 1'b1;
        cyc(4);
        afc_offset = 7'h11;
        cyc(4);
        check("offset_hold", offset_status, 7'h23);
        host_afc_en = 1'b0;
        cyc(5);
        check("offset_new", offset_status, 7'h11);
        low_power_wake_mode = 1'b1;
        wait_pwr(3'b110, 3'b100, 100);
        check("xtal_only", pwr & 3'b110, 3'b100);
        wait_pwr(3'b010, 3'b010, 10);
        check("synth_on", pwr.synth_en, 1'b1);
        wait_pwr(3'b010, 3'b000, 20);
        check("synth_off", pwr.synth_en, 1'b0);
        rssi_above = 1'b1;
        wait_pwr(3'b010, 3'b010, 60);
        cyc(12);
        check("synth_ext", pwr.synth_en, 1'b1);
        rssi_above = 1'b0;
        wait_pwr(3'b010, 3'b000, 60);
        wait_pwr(3'b010, 3'b010, 60);
        // Sync lands inside the window and must stretch it
        u_remote_tx.send_frame(8'hb2, 8'h00, 8'hff);
        cyc(6);
        check("sync_restart", pwr.synth_en, 1'b1);
        wait_pwr(3'b110, 3'b100, 60);
        low_power_wake_mode = 1'b0;
        cyc(3);
        check("pwr_on", pwr, 3'b111);
        do_reset(1'b0);
        check("not_standalone", standalone, 1'b0);
        // Address matches the reset config, so only the mode gate refuses it
        u_remote_tx.send_frame(8'h00, 8'h66, 8'h99);
        cyc(2);
        check("refused", outs, 4'h0);
        close_out();
    end
endmodule : scd_standalone_bench
